// >>> common/fsc_pkg.sv
package fsc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int HALF_W = 12;
    localparam int FREQ_W = 24;
    localparam int CNT_W  = 12;
    localparam int INT_W  = 14;
    localparam int BCNT_W = 4;

    // ------------------------------------------------------------
    // Address decode of bits 15..12 of a serial word
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_NINC    = 4'h1;
    localparam logic [3:0] ADDR_DLT_LO  = 4'h2;
    localparam logic [3:0] ADDR_DLT_HI  = 4'h3;
    localparam logic [3:0] ADDR_FST_LO  = 4'hC;
    localparam logic [3:0] ADDR_FST_HI  = 4'hD;
    localparam logic [1:0] ADDR_INT_PFX = 2'h1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_PAIRED_BIT   = 11;
    localparam int CTL_STEP_SRC_BIT = 5;
    localparam int INT_UNIT_BIT     = 13;

    // ------------------------------------------------------------
    // Values after reset and counts
    // ------------------------------------------------------------
    localparam logic [HALF_W-1:0] CTRL_RST     = 12'h000;
    localparam logic [CNT_W-1:0]  NINC_RST     = 12'h000;
    localparam logic [FREQ_W-1:0] FREQ_RST     = 24'h000000;
    localparam logic [INT_W-1:0]  INT_RST      = 14'h0001;
    localparam logic [BCNT_W-1:0] BCNT_LAST    = 4'hF;
    localparam logic [BCNT_W-1:0] BCNT_RST     = 4'h0;
    localparam logic [WORD_W-1:0] WORD_RST     = 16'h0000;

endpackage : fsc_pkg

// >>> hw/fsc_serial_rx.sv
`timescale 1ns/1ps
module fsc_serial_rx (
    // Link side, clocked by the host serial clock
    input  wire logic                        sclk,
    input  wire logic                        rstn,
    input  wire logic                        frame_select_n,
    input  wire logic                        serial_data_in,
    // Completed word, qualified by a toggle
    output logic      [fsc_pkg::WORD_W-1:0]  word_r,
    output logic                             word_tgl_r
);

    logic                        clr_async;
    logic [fsc_pkg::BCNT_W-1:0]  bcnt_r;
    logic [fsc_pkg::BCNT_W-1:0]  bcnt_nxt;
    logic [fsc_pkg::WORD_W-1:0]  shift_r;
    logic [fsc_pkg::WORD_W-1:0]  shift_nxt;
    logic [fsc_pkg::WORD_W-1:0]  word_nxt;
    logic                        word_tgl_nxt;

    // Frame high clears at once, since the serial clock may stand still
    assign clr_async = frame_select_n | ~rstn;

    always_comb begin
        bcnt_nxt     = bcnt_r + 4'h1;
        shift_nxt    = {shift_r[fsc_pkg::WORD_W-2:0], serial_data_in};
        word_nxt     = word_r;
        word_tgl_nxt = word_tgl_r;
        if (bcnt_r == fsc_pkg::BCNT_LAST) begin
            word_nxt     = shift_nxt;
            word_tgl_nxt = ~word_tgl_r;
        end
    end

    always_ff @(negedge sclk or posedge clr_async) begin
        if (clr_async) begin
            bcnt_r  <= fsc_pkg::BCNT_RST;
            shift_r <= fsc_pkg::WORD_RST;
        end else begin
            bcnt_r  <= bcnt_nxt;
            shift_r <= shift_nxt;
        end
    end

    // Word and toggle survive frame high; only the reset clears them
    always_ff @(negedge sclk or negedge rstn) begin
        if (!rstn) begin
            word_r     <= fsc_pkg::WORD_RST;
            word_tgl_r <= 1'b0;
        end else begin
            word_r     <= word_nxt;
            word_tgl_r <= word_tgl_nxt;
        end
    end

    AST_WORD_AT_16: assert property (@(negedge sclk) disable iff (clr_async)
        (bcnt_r == fsc_pkg::BCNT_LAST) |=> (word_tgl_r != $past(word_tgl_r)))
        else $error("word not committed on sixteenth falling edge");

    AST_NO_EARLY_WORD: assert property (@(negedge sclk) disable iff (clr_async)
        (bcnt_r != fsc_pkg::BCNT_LAST) |=> $stable(word_tgl_r))
        else $error("word committed before sixteen bits");

endmodule : fsc_serial_rx

// >>> hw/fsc_core.sv
// Functional notes
// - Scan set by start, step, count
// - Auto or external stepping modes
// - Auto interval in clocks or output cycles
// - Auto: one trigger runs whole scan
// - External: first edge starts, later edges step
// - Steps change increment only, phase kept
// - Final frequency held until control write or abort
// - Scan dwells count plus one intervals
// - Sixteen-bit words, several per frame
// - Bits accepted only while frame low
// - Shift on falling serial clock edges
// - Every sixteen bits form one word
// - Serial clock may idle high or low
// - Control write equals abort: reset, midscale
// - Midscale until trigger starts scan
// - Address zero selects twelve-bit control register
// - Decode count, step, interval, start addresses
// - Paired mode loads halves together
// - Step source bit one means external
`timescale 1ns/1ps
module fsc_core #(
    parameter int DAC_W = 10
) (
    // Clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // Serial write port
    input  wire logic                        sclk,
    input  wire logic                        frame_select_n,
    input  wire logic                        serial_data_in,
    // Control pins
    input  wire logic                        scan_trigger,
    input  wire logic                        abort,
    // Synthesis outputs
    output logic      [DAC_W-1:0]            dac_code_r,
    output logic      [fsc_pkg::FREQ_W-1:0]  cur_freq_r,
    output logic                             scan_active,
    output logic                             scan_done
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DAC_W < 2 || DAC_W > fsc_pkg::FREQ_W) begin : g_bad_dac_w
        $error("DAC_W out of range");
    end

    localparam logic [DAC_W-1:0] MIDSCALE = {1'b1, {(DAC_W-1){1'b0}}};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_HOLD = 3'b100
    } fsc_state_t;

    // ------------------------------------------------------------
    // Serial receiver in the serial clock domain
    // ------------------------------------------------------------
    logic [fsc_pkg::WORD_W-1:0]  link_word;
    logic                        link_tgl;

    fsc_serial_rx u_rx (
        .sclk           (sclk),
        .rstn           (rstn),
        .frame_select_n (frame_select_n),
        .serial_data_in (serial_data_in),
        .word_r         (link_word),
        .word_tgl_r     (link_tgl)
    );

    // ------------------------------------------------------------
    // Synchronisers and edge detection
    // ------------------------------------------------------------
    logic [2:0]  tgl_sync_r;
    logic [2:0]  tgl_sync_nxt;
    logic [2:0]  trig_sync_r;
    logic [2:0]  trig_sync_nxt;
    logic [2:0]  abort_sync_r;
    logic [2:0]  abort_sync_nxt;
    logic        word_valid;
    logic        trig_rise;
    logic        abort_rise;

    always_comb begin
        tgl_sync_nxt   = {tgl_sync_r[1:0], link_tgl};
        trig_sync_nxt  = {trig_sync_r[1:0], scan_trigger};
        abort_sync_nxt = {abort_sync_r[1:0], abort};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tgl_sync_r   <= 3'h0;
            trig_sync_r  <= 3'h0;
            abort_sync_r <= 3'h0;
        end else if (ce) begin
            tgl_sync_r   <= tgl_sync_nxt;
            trig_sync_r  <= trig_sync_nxt;
            abort_sync_r <= abort_sync_nxt;
        end
    end

    // Word is stable for sixteen serial clocks after its toggle, far beyond the sync delay
    assign word_valid = tgl_sync_r[2] ^ tgl_sync_r[1];
    assign trig_rise  = trig_sync_r[1] & ~trig_sync_r[2];
    assign abort_rise = abort_sync_r[1] & ~abort_sync_r[2];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [3:0]                  waddr;
    logic [fsc_pkg::HALF_W-1:0]  wdata;
    logic                        ctrl_wr;
    logic                        kill;
    logic [fsc_pkg::HALF_W-1:0]  scan_mode_config_r;
    logic [fsc_pkg::HALF_W-1:0]  scan_mode_config_nxt;
    logic [fsc_pkg::CNT_W-1:0]   increment_count_r;
    logic [fsc_pkg::CNT_W-1:0]   increment_count_nxt;
    logic [fsc_pkg::INT_W-1:0]   interval_r;
    logic [fsc_pkg::INT_W-1:0]   interval_nxt;
    logic [fsc_pkg::FREQ_W-1:0]  start_freq_r;
    logic [fsc_pkg::FREQ_W-1:0]  start_freq_nxt;
    logic [fsc_pkg::FREQ_W-1:0]  delta_r;
    logic [fsc_pkg::FREQ_W-1:0]  delta_nxt;
    logic [fsc_pkg::HALF_W-1:0]  fst_lo_pend_r;
    logic [fsc_pkg::HALF_W-1:0]  fst_lo_pend_nxt;
    logic [fsc_pkg::HALF_W-1:0]  dlt_lo_pend_r;
    logic [fsc_pkg::HALF_W-1:0]  dlt_lo_pend_nxt;
    logic                        paired_write_mode;
    logic                        step_source_select;

    assign waddr              = link_word[fsc_pkg::WORD_W-1:fsc_pkg::HALF_W];
    assign wdata              = link_word[fsc_pkg::HALF_W-1:0];
    assign ctrl_wr            = word_valid && (waddr == fsc_pkg::ADDR_CTRL);
    assign kill               = ctrl_wr | abort_rise;
    assign paired_write_mode  = scan_mode_config_r[fsc_pkg::CTL_PAIRED_BIT];
    assign step_source_select = scan_mode_config_r[fsc_pkg::CTL_STEP_SRC_BIT];

    always_comb begin
        scan_mode_config_nxt = scan_mode_config_r;
        increment_count_nxt  = increment_count_r;
        interval_nxt         = interval_r;
        start_freq_nxt       = start_freq_r;
        delta_nxt            = delta_r;
        fst_lo_pend_nxt      = fst_lo_pend_r;
        dlt_lo_pend_nxt      = dlt_lo_pend_r;
        if (word_valid) begin
            if (waddr[3:2] == fsc_pkg::ADDR_INT_PFX) begin
                interval_nxt = link_word[fsc_pkg::INT_W-1:0];
            end else begin
                case (waddr)
                    fsc_pkg::ADDR_CTRL: begin
                        scan_mode_config_nxt = wdata;
                    end
                    fsc_pkg::ADDR_NINC: begin
                        increment_count_nxt = wdata;
                    end
                    fsc_pkg::ADDR_DLT_LO: begin
                        if (paired_write_mode) begin
                            dlt_lo_pend_nxt = wdata;
                        end else begin
                            delta_nxt[fsc_pkg::HALF_W-1:0] = wdata;
                        end
                    end
                    fsc_pkg::ADDR_DLT_HI: begin
                        if (paired_write_mode) begin
                            delta_nxt = {wdata, dlt_lo_pend_r};
                        end else begin
                            delta_nxt[fsc_pkg::FREQ_W-1:fsc_pkg::HALF_W] = wdata;
                        end
                    end
                    fsc_pkg::ADDR_FST_LO: begin
                        if (paired_write_mode) begin
                            fst_lo_pend_nxt = wdata;
                        end else begin
                            start_freq_nxt[fsc_pkg::HALF_W-1:0] = wdata;
                        end
                    end
                    fsc_pkg::ADDR_FST_HI: begin
                        if (paired_write_mode) begin
                            start_freq_nxt = {wdata, fst_lo_pend_r};
                        end else begin
                            start_freq_nxt[fsc_pkg::FREQ_W-1:fsc_pkg::HALF_W] = wdata;
                        end
                    end
                    default: begin
                        // Reserved codes are ignored
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scan_mode_config_r <= fsc_pkg::CTRL_RST;
            increment_count_r  <= fsc_pkg::NINC_RST;
            interval_r         <= fsc_pkg::INT_RST;
            start_freq_r       <= fsc_pkg::FREQ_RST;
            delta_r            <= fsc_pkg::FREQ_RST;
            fst_lo_pend_r      <= fsc_pkg::CTRL_RST;
            dlt_lo_pend_r      <= fsc_pkg::CTRL_RST;
        end else if (ce) begin
            scan_mode_config_r <= scan_mode_config_nxt;
            increment_count_r  <= increment_count_nxt;
            interval_r         <= interval_nxt;
            start_freq_r       <= start_freq_nxt;
            delta_r            <= delta_nxt;
            fst_lo_pend_r      <= fst_lo_pend_nxt;
            dlt_lo_pend_r      <= dlt_lo_pend_nxt;
        end
    end

    // ------------------------------------------------------------
    // Scan state machine and phase accumulator
    // ------------------------------------------------------------
    fsc_state_t                  state_r;
    fsc_state_t                  state_nxt;
    logic [fsc_pkg::FREQ_W-1:0]  cur_freq_nxt;
    logic [fsc_pkg::FREQ_W-1:0]  phase_r;
    logic [fsc_pkg::FREQ_W-1:0]  phase_nxt;
    logic [fsc_pkg::FREQ_W-1:0]  phase_sum;
    logic [fsc_pkg::CNT_W-1:0]   steps_r;
    logic [fsc_pkg::CNT_W-1:0]   steps_nxt;
    logic [fsc_pkg::INT_W-2:0]   ticks_r;
    logic [fsc_pkg::INT_W-2:0]   ticks_nxt;
    logic [fsc_pkg::INT_W-2:0]   int_len;
    logic [DAC_W-1:0]            dac_code_nxt;
    logic                        cycle_done;
    logic                        tick;
    logic                        step_go;

    // A zero interval is served as one tick so the scan never stalls
    assign int_len    = (interval_r[fsc_pkg::INT_W-2:0] == '0) ? 13'h0001
                                                                : interval_r[fsc_pkg::INT_W-2:0];
    // A wrap of the raw sum marks one output cycle; no loop through phase_nxt
    assign phase_sum  = phase_r + cur_freq_r;
    assign cycle_done = phase_r[fsc_pkg::FREQ_W-1] & ~phase_sum[fsc_pkg::FREQ_W-1];
    assign tick       = interval_r[fsc_pkg::INT_UNIT_BIT] ? cycle_done : 1'b1;
    assign step_go    = step_source_select ? trig_rise
                                           : (tick && (ticks_r + 13'h0001 >= int_len));

    always_comb begin
        state_nxt    = state_r;
        cur_freq_nxt = cur_freq_r;
        steps_nxt    = steps_r;
        ticks_nxt    = ticks_r;
        phase_nxt    = phase_sum;
        dac_code_nxt = phase_nxt[fsc_pkg::FREQ_W-1 -: DAC_W];
        case (state_r)
            ST_IDLE: begin
                phase_nxt    = fsc_pkg::FREQ_RST;
                dac_code_nxt = MIDSCALE;
                if (trig_rise) begin
                    state_nxt    = ST_RUN;
                    cur_freq_nxt = start_freq_r;
                    steps_nxt    = '0;
                    ticks_nxt    = '0;
                end
            end
            ST_RUN: begin
                if (!step_source_select && tick) begin
                    ticks_nxt = ticks_r + 13'h0001;
                end
                if (step_go) begin
                    ticks_nxt = '0;
                    if (steps_r == increment_count_r) begin
                        state_nxt = ST_HOLD;
                    end else begin
                        cur_freq_nxt = cur_freq_r + delta_r;
                        steps_nxt    = steps_r + 12'h001;
                    end
                end
            end
            ST_HOLD: begin
                // Last frequency stays until a control write or abort
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (kill) begin
            state_nxt    = ST_IDLE;
            phase_nxt    = fsc_pkg::FREQ_RST;
            dac_code_nxt = MIDSCALE;
            steps_nxt    = '0;
            ticks_nxt    = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= ST_IDLE;
            cur_freq_r <= fsc_pkg::FREQ_RST;
            phase_r    <= fsc_pkg::FREQ_RST;
            steps_r    <= '0;
            ticks_r    <= '0;
            dac_code_r <= MIDSCALE;
        end else if (ce) begin
            state_r    <= state_nxt;
            cur_freq_r <= cur_freq_nxt;
            phase_r    <= phase_nxt;
            steps_r    <= steps_nxt;
            ticks_r    <= ticks_nxt;
            dac_code_r <= dac_code_nxt;
        end
    end

    assign scan_active = (state_r == ST_RUN);
    assign scan_done   = (state_r == ST_HOLD);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_start_req;
        ce && state_r == ST_IDLE && trig_rise && !kill;
    endsequence

    sequence s_run_step;
        ce && state_r == ST_RUN && step_go && !kill && steps_r != increment_count_r;
    endsequence

    AST_MIDSCALE_IDLE: assert property (
        (state_r == ST_IDLE) |-> (dac_code_r == MIDSCALE))
        else $error("output not midscale while idle");

    AST_CTRL_WRITE_RESETS: assert property (
        (ce && ctrl_wr) |=> (state_r == ST_IDLE && dac_code_r == MIDSCALE))
        else $error("control write did not reset scan");

    AST_ABORT_RESETS: assert property (
        (ce && abort_rise) |=> (state_r == ST_IDLE && phase_r == '0))
        else $error("abort did not reset scan");

    AST_START_AT_FSTART: assert property (
        s_start_req |=> (state_r == ST_RUN && cur_freq_r == $past(start_freq_r)))
        else $error("scan did not start at start frequency");

    AST_STEP_ADDS_DELTA: assert property (
        s_run_step |=> (cur_freq_r == 24'($past(cur_freq_r) + $past(delta_r))))
        else $error("step did not add step size");

    AST_PHASE_CONTINUOUS: assert property (
        s_run_step |=> (phase_r == 24'($past(phase_r) + $past(cur_freq_r))))
        else $error("phase disturbed at step");

    AST_HOLD_FOREVER: assert property (
        (ce && state_r == ST_HOLD && !kill) |=> (state_r == ST_HOLD && $stable(cur_freq_r)))
        else $error("final frequency not held");

    AST_EXT_WAITS_EDGE: assert property (
        (ce && state_r == ST_RUN && step_source_select && !trig_rise && !kill)
        |=> $stable(cur_freq_r) && $stable(steps_r))
        else $error("external mode stepped without edge");

    AST_STEP_BOUND: assert property (
        (state_r == ST_RUN) |-> (steps_r <= increment_count_r))
        else $error("more steps than programmed");

    AST_PAIRED_LOW_WAITS: assert property (
        (ce && word_valid && paired_write_mode && waddr == fsc_pkg::ADDR_FST_LO)
        |=> $stable(start_freq_r))
        else $error("paired low half loaded early");

    AST_AUTO_CLOCK_DWELL: assert property (
        (ce && state_r == ST_RUN && !step_source_select
         && !interval_r[fsc_pkg::INT_UNIT_BIT] && ticks_r + 13'h0001 < int_len && !kill)
        |=> $stable(cur_freq_r))
        else $error("auto step before interval elapsed");

endmodule : fsc_core

// >>> bench/fsc_host_model.sv
`timescale 1ns/1ps
module fsc_host_model (
    // Serial write port
    output logic sclk,
    output logic frame_select_n,
    output logic serial_data_in
);
    // Level at which the serial clock rests between frames
    bit idle_hi;

    initial begin
        idle_hi = 1'b1;
        sclk = 1'b1;
        frame_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // Short bit counts make a broken word; last low keeps the frame open
    task automatic send(input logic [15:0] w, input int nbits, input bit last);
        #0.7;
        frame_select_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            serial_data_in = w[i];
            sclk = 1'b1;
            #62.5;
            sclk = 1'b0;
            #62.5;
        end
        sclk = idle_hi;
        if (last) begin
            frame_select_n = 1'b1;
            serial_data_in = ~serial_data_in;
        end
    endtask : send
endmodule : fsc_host_model

// >>> bench/frequency_scan_controller_bench.sv
`timescale 1ns/1ps
module frequency_scan_controller_bench;
    logic                       clk;
    logic                       rstn;
    logic                       scan_trigger;
    logic                       abort;
    logic                       ce;
    logic                       sclk;
    logic                       frame_select_n;
    logic                       serial_data_in;
    logic [9:0]                 dac_code_r;
    logic [fsc_pkg::FREQ_W-1:0] cur_freq_r;
    logic                       scan_active;
    logic                       scan_done;
    int                         bad_count;
    int                         compares;

    fsc_core #(.DAC_W(10)) dut (.clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk),
        .frame_select_n(frame_select_n), .serial_data_in(serial_data_in),
        .scan_trigger(scan_trigger), .abort(abort), .dac_code_r(dac_code_r),
        .cur_freq_r(cur_freq_r), .scan_active(scan_active), .scan_done(scan_done));
    fsc_host_model host (.sclk(sclk), .frame_select_n(frame_select_n),
        .serial_data_in(serial_data_in));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Margin covers the toggle synchroniser into the clk domain
    task automatic wr(input logic [15:0] w);
        host.send(w, 16, 1'b1);
        cyc(6);
    endtask : wr
    task automatic await_active;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (scan_active !== 1'b1 && n < 40);
        if (scan_active !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask : await_active
    task automatic trig;
        @(posedge clk);
        scan_trigger <= 1'b1;
        cyc(4);
        scan_trigger <= 1'b0;
        cyc(5);
        #1;
    endtask : trig
    task automatic idle_chk;
        chk("dac", {14'h0, dac_code_r}, 24'h000200);
        chk("active", {23'h0, scan_active}, 24'h0);
        chk("done", {23'h0, scan_done}, 24'h0);
    endtask : idle_chk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_auto;
        wr(16'h00D0);
        wr(16'hC123);
        wr(16'hD001);
        host.send(16'h2010, 16, 1'b0);
        wr(16'h3000);
        wr(16'h1002);
        wr(16'h4003);
        idle_chk();
        @(posedge clk);
        scan_trigger <= 1'b1;
        await_active();
        chk("start", cur_freq_r, 24'h001123);
        @(posedge clk);
        scan_trigger <= 1'b0;
        cyc(2);
        #1;
        chk("step1", cur_freq_r, 24'h001133);
        cyc(3);
        #1;
        chk("step2", cur_freq_r, 24'h001143);
        chk("early", {23'h0, scan_done}, 24'h0);
        cyc(3);
        #1;
        chk("hold", {23'h0, scan_done}, 24'h1);
        trig();
        chk("final", cur_freq_r, 24'h001143);
    endtask : t_auto
    task automatic t_ext;
        wr(16'h08F0);
        wr(16'hC456);
        trig();
        chk("pend", cur_freq_r, 24'h001123);
        trig();
        chk("ext1", cur_freq_r, 24'h001133);
        trig();
        chk("ext2", cur_freq_r, 24'h001143);
        trig();
        chk("exthold", {23'h0, scan_done}, 24'h1);
        wr(16'hD002);
        wr(16'h08F0);
        idle_chk();
        trig();
        chk("pair", cur_freq_r, 24'h002456);
    endtask : t_ext
    // Interval counted in output cycles, serial clock resting low
    task automatic t_cycles;
        host.idle_hi = 1'b0;
        wr(16'h00D0);
        wr(16'hC000);
        wr(16'hD400);
        wr(16'h2000);
        wr(16'h3400);
        wr(16'h1001);
        wr(16'h6002);
        trig();
        cyc(1);
        #1;
        chk("cycdac", {14'h0, dac_code_r}, 24'h000300);
        chk("cycdwell", cur_freq_r, 24'h400000);
        cyc(1);
        #1;
        chk("cycstep", cur_freq_r, 24'h800000);
        cyc(3);
        #1;
        chk("cycearly", {23'h0, scan_done}, 24'h0);
        cyc(1);
        #1;
        chk("cychold", {23'h0, scan_done}, 24'h1);
    endtask : t_cycles
    task automatic t_refuse;
        host.send(16'hCFFF, 8, 1'b1);
        wr(16'hE777);
        wr(16'h9777);
        wr(16'h00F0);
        wr(16'hC789);
        trig();
        chk("half", cur_freq_r, 24'h002789);
        @(posedge clk);
        ce <= 1'b0;
        trig();
        @(posedge clk);
        ce <= 1'b1;
        cyc(4);
        #1;
        chk("frozen", cur_freq_r, 24'h002789);
        @(posedge clk);
        abort <= 1'b1;
        cyc(4);
        abort <= 1'b0;
        cyc(4);
        #1;
        idle_chk();
    endtask : t_refuse

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        scan_trigger = 1'b0;
        abort = 1'b0;
        ce = 1'b1;
        bad_count = 0;
        compares = 0;
        cyc(4);
        rstn <= 1'b1;
        cyc(2);
        #1;
        idle_chk();
        t_auto();
        t_ext();
        t_refuse();
        t_cycles();
        end_sim();
    end
endmodule : frequency_scan_controller_bench
